// file: hw/spc_regs.vh
// constants for the segment protection checker
//
// Functional notes
// [R1] granularity clear: 20-bit limit field is the byte limit, up to fffff
// [R2] granularity set: limit scaled by 4k, low 12 offset bits unchecked
// [R3] normal segments fault past limit, limit-1, -3, -7 by access size
// [R4] expand-down: valid from limit+1 to ffffffff or ffff by big flag
// [R5] selector indices checked against 16-bit global and interrupt limits
// [R6] local table and task registers hold 32-bit limits, bound accesses
// [R7] descriptor class from application flag plus 4-bit type field
// [R8] code-segment register loads only code segment descriptors
// [R9] data registers refuse system and non-readable code segments
// [R10] stack register accepts only writable data segments
// [R11] no writes to code or read-only data; code reads need readable
// [R12] far call or jump targets: code, call gate, task gate, task segment
// [R13] table loads and rights/limit reads need their listed types
// [R14] interrupt table entries must be interrupt or trap gates; code also accepts task gates naming a task segment
// [R15] task switch needs task segment or gate naming a task segment
// [R16] call, trap and interrupt gates must name a code segment
// [R17] null selector into code or stack register faults
// [R18] null in data register allowed, later access through it faults
// [R19] four levels 0..3, larger is less privileged; violation faults
// [R20] current level kept per code/stack, changed on transfer, not conforming
// [R21] access needs current level at or below descriptor level; gates reversed (code tests gates like data, reverses only for conforming code)
// [R22] requestor level from selector bits 1:0, larger of two governs
// [R23] all checks answered before the memory cycle starts
// [R24] descriptor level from bits 14:13 of second doubleword
// [R25] limit from first dword bits 15:0 and second dword bits 19:16
// [R26] one allow-or-fault answer; state unchanged on fault
`ifndef SPC_REGS_VH
`define SPC_REGS_VH
// operations
`define SPC_OP_ACCESS     4'h0
`define SPC_OP_LOAD_SEG   4'h1
`define SPC_OP_FAR_XFER   4'h2
`define SPC_OP_LOAD_LOCAL 4'h3
`define SPC_OP_LOAD_TASK  4'h4
`define SPC_OP_RIGHTS     4'h5
`define SPC_OP_SEG_LIMIT  4'h6
`define SPC_OP_INTERRUPT  4'h7
`define SPC_OP_TASK_SW    4'h8
`define SPC_OP_TASK_RET   4'h9
`define SPC_OP_SET_GLOBAL 4'ha
`define SPC_OP_SET_INTR   4'hb
`define SPC_OP_SYS_ACCESS 4'hc
// segment register selects
`define SPC_SEG_CODE  3'h0
`define SPC_SEG_STACK 3'h1
// descriptor field positions, second doubleword; SPC_LO_LIM is in the first
`define SPC_HI_GRAN  23
`define SPC_HI_BIG   22
`define SPC_HI_LEVEL 14:13
`define SPC_HI_APP   12
`define SPC_HI_TYPE  11:8
`define SPC_HI_LIM   19:16
`define SPC_LO_LIM   15:0
// system types
`define SPC_TYPE_LOCAL 4'h2
`define SPC_TYPE_TGATE 4'h5
// reset values
`define SPC_RST_LEVEL  2'h0
`define SPC_RST_TLIM   16'hffff
`define SPC_RST_LIM32  32'h0000ffff
`define SPC_RST_NULL   4'hf
`endif

// file: hw/spc_checker.v
// segment protection checker: limit, type and privilege checks
`default_nettype none
`include "spc_regs.vh"
module spc_checker (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        req_valid,
	input  wire [3:0]  req_op,
	input  wire [2:0]  req_seg,
	input  wire [15:0] req_selector,
	input  wire [31:0] req_desc_lo,
	input  wire [31:0] req_desc_hi,
	input  wire [31:0] req_target_hi,
	input  wire [31:0] req_offset,
	input  wire [1:0]  req_size,
	input  wire        req_write,
	output reg         resp_valid,
	output reg         resp_fault,
	output reg  [1:0]  current_privilege_level,
	output reg  [3:0]  data_seg_null
);

	// held table limits
	reg [15:0] global_table_register;
	reg [15:0] interrupt_table_register;
	reg [31:0] local_table_register;
	reg [31:0] task_limit;

	// descriptor decode
	wire [3:0]  dtype;
	wire        app;
	wire [1:0]  descriptor_privilege_level;
	wire [1:0]  requestor_privilege_level;
	wire [19:0] limit20;
	wire [31:0] eff_limit;
	wire        is_code;
	wire        is_data;
	wire        code_conf;
	wire        code_read;
	wire        data_down;
	wire        data_write;
	wire        is_tss;
	wire        is_local;
	wire        is_cgate;
	wire        is_tgate;
	wire        is_igate;
	wire        tgt_code;
	wire        tgt_tss;
	wire        sel_null;
	wire [1:0]  eff_level;
	wire [32:0] last_byte;
	wire [32:0] sel_end;
	wire [2:0]  span;
	wire [31:0] down_top;

	assign dtype = req_desc_hi[`SPC_HI_TYPE];
	assign app   = req_desc_hi[`SPC_HI_APP];
	// level from second dword
	assign descriptor_privilege_level = req_desc_hi[`SPC_HI_LEVEL]; // R24
	assign requestor_privilege_level  = req_selector[1:0]; // R22
	// limit assembly
	assign limit20 = {req_desc_hi[`SPC_HI_LIM], req_desc_lo[`SPC_LO_LIM]}; // R25
	// granularity scaling
	assign eff_limit = req_desc_hi[`SPC_HI_GRAN] ?
		{limit20, 12'hfff} : // R2
		{12'h000, limit20};  // R1

	// class from application flag and type
	assign is_code    = app & dtype[3]; // R7
	assign is_data    = app & ~dtype[3]; // R7
	assign code_conf  = dtype[2];
	assign code_read  = dtype[1];
	assign data_down  = dtype[2];
	assign data_write = dtype[1];
	assign is_tss     = ~app & ~dtype[2] & dtype[0]; // R7
	assign is_local   = ~app & (dtype == `SPC_TYPE_LOCAL); // R7
	assign is_cgate   = ~app & (dtype[2:0] == 3'h4); // R7
	assign is_tgate   = ~app & (dtype == `SPC_TYPE_TGATE); // R7
	assign is_igate   = ~app & dtype[2] & dtype[1]; // R7

	// descriptor named by a call, interrupt or task gate
	assign tgt_code = req_target_hi[`SPC_HI_APP] &
		req_target_hi[11];
	assign tgt_tss  = ~req_target_hi[`SPC_HI_APP] &
		~req_target_hi[10] & req_target_hi[8];

	assign sel_null = (req_selector[15:2] == 14'h0000);
	// less privileged of current and requestor
	assign eff_level = (requestor_privilege_level >
		current_privilege_level) ? requestor_privilege_level :
		current_privilege_level; // R22

	// access span: bytes minus one per size
	assign span = (req_size == 2'h0) ? 3'h0 :
		(req_size == 2'h1) ? 3'h1 :
		(req_size == 2'h2) ? 3'h3 : 3'h7; // R3
	assign last_byte = {1'b0, req_offset} + {30'h0, span};
	assign sel_end   = {17'h0, req_selector[15:3], 3'h7};
	assign down_top  = req_desc_hi[`SPC_HI_BIG] ?
		32'hffffffff : 32'h0000ffff; // R4

	// check results
	reg       fault;
	reg       limit_bad;
	reg       table_bad;
	reg       type_bad;
	reg       priv_bad;
	reg       null_bad;
	reg [1:0] next_level;
	reg       set_null;
	reg       clr_null;

	// segment limit check, by expansion direction
	always @* begin
		if (is_data & data_down) begin
			limit_bad = (req_offset <= eff_limit) |
				(last_byte > {1'b0, down_top}); // R4
		end else begin
			limit_bad = (last_byte > {1'b0, eff_limit}); // R3
		end
	end

	// descriptor table bounds by selector table bit
	always @* begin
		if (req_selector[2]) begin
			table_bad = (sel_end > {1'b0, local_table_register}); // R6
		end else begin
			table_bad = (sel_end > {17'h0, global_table_register}); // R5
		end
	end

	// per-operation type, privilege and null checks
	always @* begin
		type_bad   = 1'b0;
		priv_bad   = 1'b0;
		null_bad   = 1'b0;
		fault      = 1'b0;
		next_level = current_privilege_level;
		set_null   = 1'b0;
		clr_null   = 1'b0;
		case (req_op)
		`SPC_OP_ACCESS: begin
			if (req_seg >= 3'h2 && req_seg <= 3'h5) begin
				null_bad = data_seg_null[req_seg[1:0] - 2'h2]; // R18
			end
			if (is_code) begin
				type_bad = req_write | ~code_read; // R11
			end else begin
				type_bad = req_write & ~data_write; // R11
			end
			fault = null_bad | type_bad | limit_bad; // R3
		end
		`SPC_OP_LOAD_SEG: begin
			if (req_seg == `SPC_SEG_CODE) begin
				null_bad = sel_null; // R17
				type_bad = ~is_code; // R8
				priv_bad = code_conf ?
					(descriptor_privilege_level >
					current_privilege_level) :
					(descriptor_privilege_level !=
					current_privilege_level); // R21
			end else if (req_seg == `SPC_SEG_STACK) begin
				null_bad = sel_null; // R17
				type_bad = ~(is_data & data_write); // R10
				priv_bad = (requestor_privilege_level !=
					current_privilege_level) |
					(descriptor_privilege_level !=
					current_privilege_level); // R19
			end else begin
				type_bad = ~app | (is_code & ~code_read); // R9
				priv_bad = ~(is_code & code_conf) &
					(descriptor_privilege_level < eff_level); // R21
			end
			if (sel_null & req_seg >= 3'h2) begin
				fault    = 1'b0; // R18
				set_null = 1'b1;
			end else begin
				fault    = null_bad | table_bad | type_bad | priv_bad;
				clr_null = (req_seg >= 3'h2);
			end
		end
		`SPC_OP_FAR_XFER: begin
			null_bad = sel_null; // R17
			type_bad = ~(is_code | is_cgate | is_tgate | is_tss); // R12
			if (is_code) begin
				priv_bad = code_conf ?
					(descriptor_privilege_level >
					current_privilege_level) :
					((descriptor_privilege_level !=
					current_privilege_level) |
					(requestor_privilege_level >
					current_privilege_level)); // R21
			end else if (is_cgate) begin
				priv_bad = (eff_level > descriptor_privilege_level); // R21
				type_bad = ~tgt_code; // R16
				// conforming target keeps the level
				if (~req_target_hi[10]) begin
					next_level = req_target_hi[`SPC_HI_LEVEL]; // R20
				end
			end else if (is_tgate) begin
				priv_bad = (eff_level > descriptor_privilege_level);
				type_bad = ~tgt_tss; // R15
			end else if (is_tss) begin
				priv_bad = (eff_level > descriptor_privilege_level);
			end
			fault = null_bad | table_bad | type_bad | priv_bad; // R19
		end
		`SPC_OP_LOAD_LOCAL: begin
			type_bad = ~is_local; // R13
			fault    = table_bad | type_bad;
		end
		`SPC_OP_LOAD_TASK: begin
			type_bad = ~is_tss; // R13
			fault    = table_bad | type_bad;
		end
		`SPC_OP_RIGHTS: begin
			type_bad = ~(app | is_local | is_tss | is_cgate |
				is_tgate); // R13
			fault    = table_bad | type_bad;
		end
		`SPC_OP_SEG_LIMIT: begin
			type_bad = ~(app | is_local | is_tss); // R13
			fault    = table_bad | type_bad;
		end
		`SPC_OP_INTERRUPT: begin
			type_bad = ~(is_igate | is_tgate) |
				(is_igate & ~tgt_code) | (is_tgate & ~tgt_tss); // R14
			fault = type_bad | ({8'h00, req_selector[7:0], 3'h7} >
				{3'h0, interrupt_table_register}); // R5
			if (is_igate & ~req_target_hi[10] & ~fault) begin
				next_level = req_target_hi[`SPC_HI_LEVEL]; // R20
			end
		end
		`SPC_OP_TASK_SW: begin
			type_bad = ~(is_tss | is_tgate) | (is_tgate & ~tgt_tss); // R15
			fault    = table_bad | type_bad;
		end
		`SPC_OP_TASK_RET: begin
			type_bad = ~is_tss; // R15
			fault    = table_bad | type_bad;
		end
		`SPC_OP_SYS_ACCESS: begin
			fault = req_seg[0] ?
				(last_byte > {1'b0, task_limit}) :
				(last_byte > {1'b0, local_table_register}); // R6
		end
		default: begin
			fault = 1'b0;
		end
		endcase
	end

	// answer one cycle after the request, ahead of memory cycle
	always @(posedge clk) begin
		if (sys_rst) begin
			resp_valid <= 1'b0;
			resp_fault <= 1'b0;
		end else begin
			resp_valid <= req_valid; // R23
			resp_fault <= req_valid & fault; // R26
		end
	end

	// state updates only on allowed requests
	always @(posedge clk) begin
		if (sys_rst) begin
			current_privilege_level  <= `SPC_RST_LEVEL;
			data_seg_null            <= `SPC_RST_NULL;
			global_table_register    <= `SPC_RST_TLIM;
			interrupt_table_register <= `SPC_RST_TLIM;
			local_table_register     <= `SPC_RST_LIM32;
			task_limit               <= `SPC_RST_LIM32;
		end else if (req_valid & ~fault) begin // R26
			current_privilege_level <= next_level; // R20
			if (set_null) begin
				data_seg_null[req_seg[1:0] - 2'h2] <= 1'b1; // R18
			end
			if (clr_null) begin
				data_seg_null[req_seg[1:0] - 2'h2] <= 1'b0;
			end
			if (req_op == `SPC_OP_SET_GLOBAL) begin
				global_table_register <= req_offset[15:0]; // R5
			end
			if (req_op == `SPC_OP_SET_INTR) begin
				interrupt_table_register <= req_offset[15:0]; // R5
			end
			if (req_op == `SPC_OP_LOAD_LOCAL) begin
				local_table_register <= eff_limit; // R6
			end
			if (req_op == `SPC_OP_LOAD_TASK) begin
				task_limit <= eff_limit; // R6
			end
		end
	end

endmodule // spc_checker
`default_nettype wire

// file: testbench/spc_checker_asserts.sv
// port assertions for the segment protection checker
`default_nettype none
`include "spc_regs.vh"
module spc_checker_asserts (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        req_valid,
	input wire logic [3:0]  req_op,
	input wire logic [2:0]  req_seg,
	input wire logic [15:0] req_selector,
	input wire logic [31:0] req_desc_lo,
	input wire logic [31:0] req_desc_hi,
	input wire logic [31:0] req_offset,
	input wire logic [1:0]  req_size,
	input wire logic        req_write,
	input wire logic        resp_valid,
	input wire logic        resp_fault,
	input wire logic [1:0]  current_privilege_level,
	input wire logic [3:0]  data_seg_null
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// request decode and last byte touched against the limit
	wire logic        nul = req_selector[15:2] == 14'h0;
	wire logic        ld = req_valid && req_op == `SPC_OP_LOAD_SEG;
	wire logic        acc = req_valid && req_op == `SPC_OP_ACCESS;
	wire logic [32:0] top = {1'b0, req_offset} + ((33'h1 << req_size) - 33'h1);
	wire logic [32:0] lim = {13'h0, req_desc_hi[19:16], req_desc_lo[15:0]};
	a_resp_next_cycle: assert property (req_valid |=> resp_valid)
		else $error("no answer one cycle after request");
	a_resp_has_cause: assert property (resp_valid |-> $past(req_valid))
		else $error("answer without request");
	a_fault_in_resp: assert property (resp_fault |-> resp_valid)
		else $error("fault outside an answer");
	a_fault_keeps_state: assert property (resp_fault |->
		$stable(current_privilege_level) && $stable(data_seg_null))
		else $error("state changed on fault");
	a_null_code_stack: assert property (ld && nul &&
		req_seg <= `SPC_SEG_STACK |=> resp_fault)
		else $error("null code or stack load allowed");
	a_null_data_load: assert property (ld && nul && req_seg == 3'h3 |=>
		!resp_fault && data_seg_null[1])
		else $error("null data load refused or not marked");
	a_null_use_fault: assert property (acc && req_seg == 3'h3 &&
		data_seg_null[1] |=> resp_fault)
		else $error("access through null register allowed");
	a_code_load_type: assert property (ld && !nul &&
		req_seg == `SPC_SEG_CODE && !req_desc_hi[11] |=> resp_fault)
		else $error("code register took non-code descriptor");
	a_write_code: assert property (acc && req_write &&
		req_desc_hi[12] && req_desc_hi[11] |=> resp_fault)
		else $error("write to code allowed");
	a_limit_over: assert property (acc && req_desc_hi[12:10] == 3'h4 &&
		!req_desc_hi[23] && top > lim |=> resp_fault)
		else $error("access past limit allowed");
endmodule // spc_checker_asserts
bind spc_checker spc_checker_asserts u_spc_checker_asserts (.clk, .sys_rst,
	.req_valid, .req_op, .req_seg, .req_selector, .req_desc_lo, .req_desc_hi,
	.req_offset, .req_size, .req_write, .resp_valid, .resp_fault,
	.current_privilege_level, .data_seg_null);
`default_nettype wire

// file: testbench/spc_host.sv
// request source standing in for the pipeline stages
`default_nettype none
module spc_host (
	input wire logic         clk,
	output var logic         req_valid,
	output wire logic [3:0]  req_op,
	output wire logic [2:0]  req_seg,
	output wire logic [15:0] req_selector,
	output wire logic [31:0] req_desc_lo,
	output wire logic [31:0] req_desc_hi,
	output wire logic [31:0] req_target_hi,
	output wire logic [31:0] req_offset,
	output wire logic [1:0]  req_size,
	output wire logic        req_write
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [153:0] b;
	// all qualifiers of a request travel together
	assign {req_op, req_seg, req_selector, req_desc_lo, req_desc_hi,
		req_target_hi, req_offset, req_size, req_write} = b;
	initial begin
		req_valid = 1'b0;
		b = '0;
	end
	// one request, fields scrambled once taken so stale values never match
	task automatic issue(input logic [3:0] o, input logic [2:0] s,
		input logic [15:0] sl, input logic [31:0] lo, hi, tg, off,
		input logic [1:0] sz, input logic w);
		@(posedge clk);
		req_valid <= 1'b1;
		b <= {o, s, sl, lo, hi, tg, off, sz, w};
		@(posedge clk);
		req_valid <= 1'b0;
		b <= ~b;
	endtask
endmodule // spc_host
`default_nettype wire

// file: testbench/spc_checker_bench.sv
// self-checking bench for the segment protection checker
`default_nettype none
`include "spc_regs.vh"
module spc_checker_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	int mismatches = 0;
	int num_checks = 0;
	wire logic        req_valid, req_write, resp_valid, resp_fault;
	wire logic [3:0]  req_op, data_seg_null;
	wire logic [2:0]  req_seg;
	wire logic [15:0] req_selector;
	wire logic [31:0] req_desc_lo, req_desc_hi, req_target_hi, req_offset;
	wire logic [1:0]  req_size, current_privilege_level;
	// descriptor second dwords: data, code, system
	localparam logic [31:0] dw = 32'h0000f200, dr = 32'h0000f000;
	localparam logic [31:0] cx = 32'h0000f800, cr = 32'h0000fa00;
	localparam logic [31:0] ed = 32'h0000f600, d0 = 32'h00009200;
	localparam logic [31:0] sy = 32'h0000e200;
	// gates and task segment, all at level 3
	localparam logic [31:0] ig = 32'h0000ee00, cg = 32'h0000ec00;
	localparam logic [31:0] ts = 32'h0000e900;
	// second dword of the descriptor a gate points at
	logic [31:0] tg = 32'h0;
	logic [3:0] fo[5] = '{`SPC_OP_FAR_XFER, `SPC_OP_LOAD_LOCAL,
		`SPC_OP_LOAD_TASK, `SPC_OP_INTERRUPT, `SPC_OP_TASK_SW};
	spc_host u_spc_host (.clk, .req_valid, .req_op, .req_seg, .req_selector,
		.req_desc_lo, .req_desc_hi, .req_target_hi, .req_offset, .req_size,
		.req_write);
	spc_checker u_spc_checker (.clk, .sys_rst, .req_valid, .req_op, .req_seg,
		.req_selector, .req_desc_lo, .req_desc_hi, .req_target_hi,
		.req_offset, .req_size, .req_write, .resp_valid, .resp_fault,
		.current_privilege_level, .data_seg_null);
	always #20 clk = ~clk;
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one request, then the answer one cycle later
	task automatic rq(input logic [3:0] o, input logic [2:0] s,
		input logic [15:0] sl, input logic [31:0] h, off,
		input logic [1:0] sz, input logic w, e);
		u_spc_host.issue(o, s, sl, 32'h000000ff, h, tg, off, sz, w);
		#1;
		chk({resp_valid, resp_fault}, {1'b1, e});
	endtask
	task automatic ld(input logic [2:0] s, input logic [15:0] sl,
		input logic [31:0] h, input logic e);
		rq(`SPC_OP_LOAD_SEG, s, sl, h, 32'h0, 2'h0, 1'b0, e);
	endtask
	task automatic ac(input logic [2:0] s, input logic [31:0] h, off,
		input logic [1:0] sz, input logic w, e);
		rq(`SPC_OP_ACCESS, s, 16'h000b, h, off, sz, w, e);
	endtask
	task automatic t_null;
		ld(3'h0, 16'h0, cr, 1'b1);
		ld(3'h1, 16'h0, dw, 1'b1);
		ld(3'h3, 16'h000b, dw, 1'b0);
		chk(data_seg_null, 4'hd);
		ld(3'h3, 16'h0, dw, 1'b0);
		chk(data_seg_null, 4'hf);
		ac(3'h3, dw, 32'h0, 2'h0, 1'b0, 1'b1);
		chk(current_privilege_level, 2'h0);
		$display("test null selectors done");
	endtask
	task automatic t_types;
		ld(3'h0, 16'h000b, dw, 1'b1);
		ld(3'h2, 16'h000b, sy, 1'b1);
		ld(3'h2, 16'h000b, cx, 1'b1);
		ld(3'h2, 16'h000b, cr, 1'b0);
		ld(3'h1, 16'h0008, 32'h00009000, 1'b1);
		ld(3'h1, 16'h0008, d0, 1'b0);
		ld(3'h2, 16'h000b, d0, 1'b1);
		ld(3'h2, 16'h0008, d0, 1'b0);
		foreach (fo[i]) rq(fo[i], 3'h0, 16'h000b, dw, '0, '0, '0, '1);
		rq(`SPC_OP_RIGHTS, 3'h0, 16'h000b, dw, '0, '0, '0, '0);
		rq(`SPC_OP_SEG_LIMIT, 3'h0, 16'h000b, dw, '0, '0, '0, '0);
		$display("test descriptor types done");
	endtask
	task automatic t_limits;
		for (int s = 0; s < 4; s++) begin
			ac(3'h2, dw, 32'h100 - (32'h1 << s), s[1:0], 1'b0, 1'b0);
			ac(3'h2, dw, 32'h101 - (32'h1 << s), s[1:0], 1'b0, 1'b1);
		end
		ac(3'h2, 32'h0080f200, 32'h000fffff, 2'h0, 1'b0, 1'b0);
		ac(3'h2, 32'h0080f200, 32'h00100000, 2'h0, 1'b0, 1'b1);
		ac(3'h2, ed, 32'hff, 2'h0, 1'b0, 1'b1);
		ac(3'h2, ed, 32'h100, 2'h0, 1'b0, 1'b0);
		ac(3'h2, ed, 32'h10000, 2'h0, 1'b0, 1'b1);
		ac(3'h2, 32'h0040f600, 32'h10000, 2'h0, 1'b0, 1'b0);
		ac(3'h2, dr, 32'h0, 2'h0, 1'b1, 1'b1);
		ac(3'h2, cr, 32'h0, 2'h0, 1'b1, 1'b1);
		ac(3'h2, cx, 32'h0, 2'h0, 1'b0, 1'b1);
		ac(3'h2, cr, 32'h0, 2'h0, 1'b0, 1'b0);
		ac(3'h2, dw, 32'h0, 2'h0, 1'b1, 1'b0);
		rq(`SPC_OP_SET_GLOBAL, 3'h0, 16'h0, dw, 32'hf, '0, '0, '0);
		ld(3'h2, 16'h000b, dw, 1'b0);
		ld(3'h2, 16'h0013, dw, 1'b1);
		$display("test limits done");
	endtask
	// gate targets, level changes, task segments and system tables
	task automatic t_xfer;
		tg = dw;
		rq(`SPC_OP_INTERRUPT, 3'h0, 16'h000b, ig, '0, '0, '0, '1);
		rq(`SPC_OP_FAR_XFER, 3'h0, 16'h000b, cg, '0, '0, '0, '1);
		chk(current_privilege_level, 2'h0);
		tg = 32'h0000fe00;
		rq(`SPC_OP_FAR_XFER, 3'h0, 16'h000b, cg, '0, '0, '0, '0);
		chk(current_privilege_level, 2'h0);
		tg = cx;
		rq(`SPC_OP_FAR_XFER, 3'h0, 16'h000b, cg, '0, '0, '0, '0);
		chk(current_privilege_level, 2'h3);
		rq(`SPC_OP_SET_INTR, 3'h0, 16'h0, dw, 32'h5f, '0, '0, '0);
		tg = 32'h00009a00;
		rq(`SPC_OP_INTERRUPT, 3'h0, 16'h000c, ig, '0, '0, '0, '1);
		rq(`SPC_OP_INTERRUPT, 3'h0, 16'h000b, ig, '0, '0, '0, '0);
		chk(current_privilege_level, 2'h0);
		rq(`SPC_OP_TASK_RET, 3'h0, 16'h000b, ts, '0, '0, '0, '0);
		rq(`SPC_OP_TASK_SW, 3'h0, 16'h000b, ts, '0, '0, '0, '0);
		rq(`SPC_OP_LOAD_TASK, 3'h0, 16'h000b, ts, '0, '0, '0, '0);
		rq(`SPC_OP_SYS_ACCESS, 3'h1, 16'h0, ts, 32'hfc, 2'h2, '0, '0);
		rq(`SPC_OP_SYS_ACCESS, 3'h1, 16'h0, ts, 32'hfd, 2'h2, '0, '1);
		rq(`SPC_OP_LOAD_LOCAL, 3'h0, 16'h000b, sy, '0, '0, '0, '0);
		ld(3'h2, 16'h00ff, dw, 1'b0);
		ld(3'h2, 16'h0107, dw, 1'b1);
		rq(`SPC_OP_SYS_ACCESS, 3'h0, 16'h0, sy, 32'h100, '0, '0, '1);
		$display("test transfers done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog well beyond the roughly 120 cycles the tests need
	initial begin
		#20000;
		mismatches++;
		final_report;
	end
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk({current_privilege_level, data_seg_null}, 6'h0f);
		t_null;
		t_types;
		t_limits;
		t_xfer;
		final_report;
	end
endmodule // spc_checker_bench
`default_nettype wire
